// ---- common/acg_pkg.sv ----
package acg_pkg;
   // register map
   localparam logic [7:0] ACG_CLK_SRC_SEL_OFFSET = 8'h66;
   localparam logic [7:0] ACG_CLK_SRC_SEL_RESET  = 8'h00;
   localparam int         ACG_DIV_SRC_MSB        = 7;
   localparam int         ACG_DIV_SRC_LSB        = 6;
   localparam int         ACG_LOOP_SRC_MSB       = 5;
   localparam int         ACG_LOOP_SRC_LSB       = 4;
   localparam logic [7:0] ACG_CLK_SRC_SEL_MASK   = 8'hF0;

   // source encodings of both two-bit selectors
   localparam logic [1:0] ACG_SRC_MCLK  = 2'h0;
   localparam logic [1:0] ACG_SRC_BCLK  = 2'h1;
   localparam logic [1:0] ACG_SRC_SPARE = 2'h2;

   // ratio ranges
   localparam logic [4:0]  ACG_Q_MIN     = 5'h02;
   localparam logic [4:0]  ACG_Q_MAX     = 5'h11;
   localparam logic [3:0]  ACG_P_MIN     = 4'h1;
   localparam logic [3:0]  ACG_P_MAX     = 4'h8;
   localparam logic [4:0]  ACG_R_MIN     = 5'h01;
   localparam logic [4:0]  ACG_R_MAX     = 5'h10;
   localparam logic [6:0]  ACG_J_MIN     = 7'h01;
   localparam logic [6:0]  ACG_J_MAX     = 7'h40;
   localparam logic [13:0] ACG_D_MAX     = 14'h270F;
   localparam logic [4:0]  ACG_N_MIN     = 5'h02;
   localparam logic [4:0]  ACG_N_MAX     = 5'h11;
   localparam logic [3:0]  ACG_HALF_MIN  = 4'h2;
   localparam logic [3:0]  ACG_HALF_MAX  = 4'hC;

   // arithmetic constants
   localparam logic [31:0] ACG_FRAC_SCALE   = 32'h0000_2710;
   localparam logic [31:0] ACG_MCLK_PER_FS  = 32'h0000_0100;
   localparam logic [31:0] ACG_DIV_STEP     = 32'h0000_0002;
   localparam logic [31:0] ACG_DUAL_STEP    = 32'h0000_0004;
   localparam logic [2:0]  ACG_VCO_TO_MCLK  = 3'h7;
   localparam logic [31:0] ACG_ACC_CAP      = 32'h4000_0000;
endpackage

// ---- core/acg_audio_clock_generator.sv ----
// Summary of operation
// - internal converter master clock runs at 256 times the reference rate
// - master clock pin feeds either integer divider or the loop multiplier
// - bit clock pin or spare input pin may also source the master clock
// - loop off: reference rate is source divided by 128 times Q, Q 2..17
// - bits 7..6 of clock_source_select pick the divider source clock
// - loop on: reference rate is source times K times R over 2048 P
// - bits 5..4 of clock_source_select pick the loop source clock
// - multiplier K is integer part J plus four-digit fraction D
// - while powered down, spare pin may drive the loop and the clock pin
// - mux select 0 with loop on: pin clock is source 2KR over MNP
// - mux select 1: pin clock is divider source times 2 over M times N
// - sample rates are reference or twice it over half-step divider 1..6
`timescale 1ns/1ps
module acg_audio_clock_generator
   import acg_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   input  wire logic        mclk_pin,
   input  wire logic        bclk_pin,
   input  wire logic        spare_clock_input_pin,
   input  wire logic        reg_wr_en,
   input  wire logic [7:0]  reg_wr_data,
   output logic      [7:0]  reg_rd_data,
   input  wire logic        pll_enable,
   input  wire logic [3:0]  pll_p,
   input  wire logic [4:0]  pll_r,
   input  wire logic [6:0]  pll_j,
   input  wire logic [13:0] pll_d,
   input  wire logic [4:0]  div_q,
   input  wire logic [1:0]  clkout_m_sel,
   input  wire logic [4:0]  clkout_n,
   input  wire logic        output_mux_select,
   input  wire logic [3:0]  dac_rate_divider,
   input  wire logic [3:0]  adc_rate_divider,
   input  wire logic        dac_dual_rate,
   input  wire logic        adc_dual_rate,
   input  wire logic        dac_enable,
   input  wire logic        adc_enable,
   input  wire logic        clkout_enable,
   input  wire logic        codec_powered_down,
   output logic             conv_mclk_tick,
   output logic             dac_fs_tick,
   output logic             adc_fs_tick,
   output logic             clkout_tick,
   output logic             clock_output_pin,
   output logic             cfg_pending
);
   import acg_pkg::*;

   // one accumulator step of a rate divider: returns {pulse, next accumulator}
   function automatic logic [32:0] acg_rate_step(input logic [31:0] acc,
                                                 input logic        in_tick,
                                                 input logic [31:0] add,
                                                 input logic [31:0] thr);
      logic [31:0] sum;
      sum = acc;
      if (in_tick && (acc < ACG_ACC_CAP)) begin
         sum = acc + add;
      end
      if (sum >= thr) begin
         acg_rate_step = {1'b1, sum - thr};
      end else begin
         acg_rate_step = {1'b0, sum};
      end
   endfunction

   // clamps a 5-bit ratio into its legal range
   function automatic logic [4:0] acg_clamp5(input logic [4:0] v,
                                             input logic [4:0] lo,
                                             input logic [4:0] hi);
      acg_clamp5 = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   // clamps a 4-bit ratio into its legal range
   function automatic logic [3:0] acg_clamp4(input logic [3:0] v,
                                             input logic [3:0] lo,
                                             input logic [3:0] hi);
      acg_clamp4 = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   logic [7:0]  clk_src_sel_reg;
   logic [2:0]  pin_prev_reg;
   logic [2:0]  pin_rise;
   logic [55:0] cfg_live;
   logic [55:0] cfg_reg;
   logic        consumers_idle;
   logic        cfg_pending_reg;
   logic [1:0]  div_src_sel;
   logic [1:0]  loop_src_sel;
   logic        pll_on;
   logic [3:0]  act_p;
   logic [4:0]  act_r;
   logic [6:0]  act_j;
   logic [13:0] act_d;
   logic [4:0]  act_q;
   logic [1:0]  act_m_sel;
   logic [4:0]  act_n;
   logic        act_mux;
   logic [3:0]  act_dac_half;
   logic [3:0]  act_adc_half;
   logic        div_src_tick;
   logic        loop_src_tick;
   logic [31:0] k_times_r;
   logic [31:0] vco_thr;
   logic [31:0] m_times_n;
   logic [31:0] vco_acc_reg;
   logic [32:0] vco_step;
   logic [31:0] div_acc_reg;
   logic [32:0] div_step;
   logic [2:0]  vco_div_reg;
   logic        vco_tick_reg;
   logic        mclk_from_div;
   logic        mclk_from_vco;
   logic        mclk_int;
   logic [31:0] out_acc_reg;
   logic [32:0] out_step;
   logic        out_src_tick;
   logic [31:0] dac_acc_reg;
   logic [31:0] adc_acc_reg;
   logic [32:0] dac_step;
   logic [32:0] adc_step;

   // clock_source_select register, upper nibble held, lower nibble reads zero
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         clk_src_sel_reg <= ACG_CLK_SRC_SEL_RESET;
      end else if (reg_wr_en) begin
         clk_src_sel_reg <= reg_wr_data & ACG_CLK_SRC_SEL_MASK;
      end
   end

   assign reg_rd_data = clk_src_sel_reg;

   // edge detection of the externally supplied clock pins
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_prev_reg <= 3'h0;
      end else begin
         pin_prev_reg <= {spare_clock_input_pin, bclk_pin, mclk_pin};
      end
   end

   assign pin_rise = {spare_clock_input_pin, bclk_pin, mclk_pin} & ~pin_prev_reg;

   // live settings gathered for the shadow copy
   assign cfg_live = {clk_src_sel_reg[7:4], pll_enable, pll_p, pll_r, pll_j, pll_d,
                      div_q, clkout_m_sel, clkout_n, output_mux_select,
                      dac_rate_divider, adc_rate_divider};
   assign consumers_idle = !dac_enable && !adc_enable && !clkout_enable;

   // glitch-free update
   // settings are copied only while no consumer is enabled
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_reg         <= 56'h0;
         cfg_pending_reg <= 1'b0;
      end else begin
         if (consumers_idle) begin
            cfg_reg <= cfg_live;
         end
         cfg_pending_reg <= !consumers_idle && (cfg_live != cfg_reg);
      end
   end

   assign cfg_pending = cfg_pending_reg;

   // unpack the applied settings and clamp each ratio to its range
   assign div_src_sel  = cfg_reg[55:54];
   assign loop_src_sel = cfg_reg[53:52];
   assign pll_on       = cfg_reg[51];
   assign act_p        = acg_clamp4(cfg_reg[50:47], ACG_P_MIN, ACG_P_MAX);
   assign act_r        = acg_clamp5(cfg_reg[46:42], ACG_R_MIN, ACG_R_MAX);
   assign act_j        = (cfg_reg[41:35] < ACG_J_MIN) ? ACG_J_MIN :
                         ((cfg_reg[41:35] > ACG_J_MAX) ? ACG_J_MAX : cfg_reg[41:35]);
   assign act_d        = (cfg_reg[34:21] > ACG_D_MAX) ? ACG_D_MAX : cfg_reg[34:21];
   assign act_q        = acg_clamp5(cfg_reg[20:16], ACG_Q_MIN, ACG_Q_MAX);
   assign act_m_sel    = cfg_reg[15:14];
   assign act_n        = acg_clamp5(cfg_reg[13:9], ACG_N_MIN, ACG_N_MAX);
   assign act_mux      = cfg_reg[8];
   assign act_dac_half = acg_clamp4(cfg_reg[7:4], ACG_HALF_MIN, ACG_HALF_MAX);
   assign act_adc_half = acg_clamp4(cfg_reg[3:0], ACG_HALF_MIN, ACG_HALF_MAX);

   always_comb begin
      unique case (div_src_sel)
         ACG_SRC_BCLK:  div_src_tick = pin_rise[1];
         ACG_SRC_SPARE: div_src_tick = pin_rise[2];
         default:       div_src_tick = pin_rise[0];
      endcase
   end

   // spare pin only while powered down
   always_comb begin
      unique case (loop_src_sel)
         ACG_SRC_BCLK:  loop_src_tick = pin_rise[1];
         ACG_SRC_SPARE: loop_src_tick = codec_powered_down && pin_rise[2];
         default:       loop_src_tick = pin_rise[0];
      endcase
   end

   // multiplier K
   // K times R scaled by the fraction base, vco threshold is P scaled alike
   assign k_times_r = ({25'h0, act_j} * ACG_FRAC_SCALE + {18'h0, act_d}) * {27'h0, act_r};
   assign vco_thr   = {28'h0, act_p} * ACG_FRAC_SCALE;
   assign m_times_n = ({27'h0, act_n} << act_m_sel);

   // loop rate
   // vco ticks at source times K times R over P
   assign vco_step = acg_rate_step(vco_acc_reg, loop_src_tick, k_times_r, vco_thr);

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         vco_acc_reg  <= 32'h0;
         vco_tick_reg <= 1'b0;
         vco_div_reg  <= 3'h0;
      end else if (!pll_on) begin
         vco_acc_reg  <= 32'h0;
         vco_tick_reg <= 1'b0;
         vco_div_reg  <= 3'h0;
      end else begin
         vco_acc_reg  <= vco_step[31:0];
         vco_tick_reg <= vco_step[32];
         if (vco_step[32]) begin
            vco_div_reg <= vco_div_reg + 3'h1;
         end
      end
   end

   // integer divider
   // two master ticks per Q source edges gives source over 128 Q times 256
   assign div_step = acg_rate_step(div_acc_reg, div_src_tick, ACG_DIV_STEP,
                                   {27'h0, act_q});

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         div_acc_reg <= 32'h0;
      end else if (pll_on) begin
         div_acc_reg <= 32'h0;
      end else begin
         div_acc_reg <= div_step[31:0];
      end
   end

   // master clock
   // 256 times reference: vco over 8 with the loop, divider otherwise, none while powered down
   assign mclk_from_div = !pll_on && div_step[32];
   assign mclk_from_vco = vco_tick_reg && (vco_div_reg == ACG_VCO_TO_MCLK);
   assign mclk_int      = (pll_on && !codec_powered_down) ? mclk_from_vco :
                          ((!pll_on && !codec_powered_down) ? mclk_from_div : 1'b0);

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         conv_mclk_tick <= 1'b0;
      end else begin
         conv_mclk_tick <= mclk_int;
      end
   end

   // output divider source
   // mux 0 takes the vco, mux 1 the divider source regardless of loop state
   assign out_src_tick = act_mux ? div_src_tick : (pll_on && vco_tick_reg);
   assign out_step     = acg_rate_step(out_acc_reg, out_src_tick, ACG_DUAL_STEP,
                                       m_times_n);

   // output divider: four ticks per source tick over M N, pin toggles on each tick
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         out_acc_reg      <= 32'h0;
         clkout_tick      <= 1'b0;
         clock_output_pin <= 1'b0;
      end else if (!clkout_enable) begin
         out_acc_reg      <= 32'h0;
         clkout_tick      <= 1'b0;
         clock_output_pin <= 1'b0;
      end else begin
         out_acc_reg <= out_step[31:0];
         clkout_tick <= out_step[32];
         if (out_step[32]) begin
            clock_output_pin <= !clock_output_pin;
         end
      end
   end

   // converter rates
   // fs is master over 256 times the half-step divider, doubled in dual rate
   assign dac_step = acg_rate_step(dac_acc_reg, conv_mclk_tick,
                                   dac_dual_rate ? ACG_DUAL_STEP : ACG_DIV_STEP,
                                   ACG_MCLK_PER_FS * {28'h0, act_dac_half});
   assign adc_step = acg_rate_step(adc_acc_reg, conv_mclk_tick,
                                   adc_dual_rate ? ACG_DUAL_STEP : ACG_DIV_STEP,
                                   ACG_MCLK_PER_FS * {28'h0, act_adc_half});

   // dac sample rate divider
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         dac_acc_reg <= 32'h0;
         dac_fs_tick <= 1'b0;
      end else if (!dac_enable) begin
         dac_acc_reg <= 32'h0;
         dac_fs_tick <= 1'b0;
      end else begin
         dac_acc_reg <= dac_step[31:0];
         dac_fs_tick <= dac_step[32];
      end
   end

   // adc sample rate divider
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         adc_acc_reg <= 32'h0;
         adc_fs_tick <= 1'b0;
      end else if (!adc_enable) begin
         adc_acc_reg <= 32'h0;
         adc_fs_tick <= 1'b0;
      end else begin
         adc_acc_reg <= adc_step[31:0];
         adc_fs_tick <= adc_step[32];
      end
   end

endmodule // acg_audio_clock_generator

// ---- test/acg_chk.sv ----
`timescale 1ns/1ps
module acg_chk
   import acg_pkg::*;
(
   input wire logic       sys_clk,
   input wire logic       arst_n,
   input wire logic       reg_wr_en,
   input wire logic [7:0] reg_wr_data,
   input wire logic [7:0] reg_rd_data,
   input wire logic       dac_enable,
   input wire logic       adc_enable,
   input wire logic       clkout_enable,
   input wire logic       codec_powered_down,
   input wire logic       conv_mclk_tick,
   input wire logic       dac_fs_tick,
   input wire logic       adc_fs_tick,
   input wire logic       clkout_tick,
   input wire logic       clock_output_pin,
   input wire logic       cfg_pending
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   // consumers idle long enough for the applied copy to catch up
   sequence s_all_off;
      !(dac_enable || adc_enable || clkout_enable) [*3];
   endsequence
   // pin moves on the tick edge or the one after
   sequence s_pin_moves;
      ##[0:1] $changed(clock_output_pin);
   endsequence

   chk_reg_echo: assert property (
      reg_wr_en |=> reg_rd_data == ($past(reg_wr_data) & ACG_CLK_SRC_SEL_MASK))
      else $error("selector readback differs from write");
   chk_reg_hold: assert property (!reg_wr_en |=> $stable(reg_rd_data))
      else $error("selector changed without a write");
   chk_nibble_zero: assert property (reg_rd_data[3:0] == 4'h0)
      else $error("unused selector bits read nonzero");
   chk_pin_cause: assert property (
      $changed(clock_output_pin) |-> clkout_tick || !$past(clkout_enable))
      else $error("clock pin moved without a tick");
   chk_pin_toggle: assert property (clkout_tick |-> s_pin_moves)
      else $error("tick did not move the clock pin");
   chk_dac_quiet: assert property (!dac_enable [*3] |-> !dac_fs_tick)
      else $error("dac sample tick while disabled");
   chk_adc_quiet: assert property (!adc_enable [*3] |-> !adc_fs_tick)
      else $error("adc sample tick while disabled");
   chk_out_quiet: assert property (!clkout_enable [*3] |-> !clkout_tick)
      else $error("output tick while disabled");
   chk_pd_quiet: assert property (codec_powered_down [*3] |-> !conv_mclk_tick)
      else $error("converter clock while powered down");
   chk_pend_idle: assert property (s_all_off |-> !cfg_pending)
      else $error("settings pending with all consumers idle");
endmodule // acg_chk

bind acg_audio_clock_generator acg_chk chk_u (.*);

// ---- test/acg_src_model.sv ----
`timescale 1ns/1ps
module acg_src_model #(
   parameter int HALF_MCLK  = 2,
   parameter int HALF_BCLK  = 3,
   parameter int HALF_SPARE = 5
) (
   input  wire logic sys_clk,
   input  wire logic arst_n,
   output logic      mclk_pin,
   output logic      bclk_pin,
   output logic      spare_clock_input_pin
);
   localparam int HALF_C [3] = '{HALF_MCLK, HALF_BCLK, HALF_SPARE};
   int         cnt_q [3];
   logic [2:0] pin_q;

   // clocks always supplied
   // free-running sources, each slower than half the system clock
   always @(negedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_q <= 3'h0;
         cnt_q <= '{default: 0};
      end else begin
         for (int i = 0; i < 3; i++) begin
            cnt_q[i] <= (cnt_q[i] == HALF_C[i] - 1) ? 0 : cnt_q[i] + 1;
            if (cnt_q[i] == HALF_C[i] - 1)
               pin_q[i] <= ~pin_q[i];
         end
      end
   end
   assign {spare_clock_input_pin, bclk_pin, mclk_pin} = pin_q;
endmodule // acg_src_model

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   import acg_pkg::*;
   logic        sys_clk = 1'b0;
   logic        arst_n, reg_wr_en, pll_enable, output_mux_select, dac_dual_rate;
   logic        adc_dual_rate, dac_enable, adc_enable, clkout_enable, codec_powered_down;
   logic        mclk_pin, bclk_pin, spare_clock_input_pin, conv_mclk_tick, dac_fs_tick;
   logic        adc_fs_tick, clkout_tick, clock_output_pin, cfg_pending;
   logic [7:0]  reg_wr_data, reg_rd_data;
   logic [3:0]  pll_p, dac_rate_divider, adc_rate_divider;
   logic [4:0]  pll_r, div_q, clkout_n;
   logic [6:0]  pll_j;
   logic [13:0] pll_d;
   logic [1:0]  clkout_m_sel;
   logic [31:0] seed = 32'h0001_09DD;
   int          err_total = 0;
   int          n_checks = 0;
   longint      cnt [8];
   wire  [2:0]  src = {spare_clock_input_pin, bclk_pin, mclk_pin};

   // 25 MHz system clock
   always #20 sys_clk = ~sys_clk;

   acg_audio_clock_generator dut_u (.*);
   acg_src_model src_u (.*);

   // lfsr step, folded into [lo, hi]
   function automatic int rnd(input int lo, input int hi);
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return lo + int'(seed % (hi - lo + 1));
   endfunction
   // sample ticks expected from converter clock ticks
   function automatic longint fs_exp(input longint c, input logic [3:0] dv, input logic dual);
      return c * (dual ? 4 : 2) / (256 * dv);
   endfunction

   // rate compare with a small phase allowance
   task automatic check(input string what, input longint got, input longint want);
      n_checks++;
      if (got > want + 2 || got + 2 < want) begin
         err_total++;
         $display("CHECK FAILED %s expected %0d seen %0d", what, want, got);
      end
   endtask
   task automatic check8(input string what, input logic [7:0] got, input logic [7:0] want);
      n_checks++;
      if (got !== want) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, want, got);
      end
   endtask
   task automatic end_of_test;
      if (err_total == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // count source edges, ticks and pin moves over n clocks
   task automatic measure(input int n);
      logic [2:0] prev;
      logic       pin_prev;
      prev = src;
      pin_prev = clock_output_pin;
      cnt = '{default: 0};
      repeat (n) begin
         @(posedge sys_clk);
         #1;
         for (int i = 0; i < 3; i++)
            cnt[i] += (prev[i] === 1'b0 && src[i] === 1'b1);
         cnt[3] += (conv_mclk_tick === 1'b1);
         cnt[4] += (dac_fs_tick === 1'b1);
         cnt[5] += (adc_fs_tick === 1'b1);
         cnt[6] += (clkout_tick === 1'b1);
         cnt[7] += (clock_output_pin !== pin_prev);
         prev = src;
         pin_prev = clock_output_pin;
      end
   endtask
   // idle the consumers and draw fresh rate and output divider settings
   task automatic pick;
      @(negedge sys_clk);
      {dac_enable, adc_enable, clkout_enable} = 3'h0;
      dac_rate_divider = 4'(rnd(2, 12));
      adc_rate_divider = 4'(rnd(2, 12));
      {dac_dual_rate, adc_dual_rate} = 2'(rnd(0, 3));
      clkout_m_sel = 2'(rnd(0, 3));
      clkout_n = 5'(rnd(2, 17));
   endtask
   // write the selectors while idle, then enable everything and measure
   task automatic run_cfg(input logic [1:0] dsrc, input logic [1:0] lsrc);
      @(negedge sys_clk);
      reg_wr_en = 1'b1;
      reg_wr_data = {dsrc, lsrc, 4'(rnd(0, 15))};
      @(negedge sys_clk);
      reg_wr_en = 1'b0;
      repeat (3) @(negedge sys_clk);
      {dac_enable, adc_enable, clkout_enable} = 3'h7;
      measure(8000);
   endtask
   task automatic verify(input longint conv, input longint out);
      check("conv_mclk_tick", cnt[3], conv);
      check("dac_fs_tick", cnt[4], fs_exp(conv, dac_rate_divider, dac_dual_rate));
      check("adc_fs_tick", cnt[5], fs_exp(conv, adc_rate_divider, adc_dual_rate));
      check("clkout_tick", cnt[6], out);
      check("clock_output_pin", cnt[7], out);
   endtask

   // main sequence
   initial begin
      int     mn;
      longint kn;
      longint kd;
      {arst_n, reg_wr_en, pll_enable, output_mux_select, codec_powered_down} = 5'h00;
      {dac_dual_rate, adc_dual_rate, dac_enable, adc_enable, clkout_enable} = 5'h00;
      {reg_wr_data, pll_p, pll_r, pll_j, pll_d, div_q} = '0;
      {clkout_m_sel, clkout_n, dac_rate_divider, adc_rate_divider} = '0;
      repeat (20) @(posedge sys_clk);
      @(negedge sys_clk);
      arst_n = 1'b1;
      @(negedge sys_clk);
      check8("reg_rd_data", reg_rd_data, ACG_CLK_SRC_SEL_RESET);
      // back-to-back selector writes, each read back one cycle later
      for (int i = 0; i < 9; i++) begin
         @(negedge sys_clk);
         if (i > 0)
            check8("reg_rd_data", reg_rd_data, reg_wr_data & ACG_CLK_SRC_SEL_MASK);
         reg_wr_en = (i < 8);
         reg_wr_data = 8'(rnd(0, 255));
      end
      // divider path from all three sources, ratio at the low limit and, with an even dac divider, the high one
      for (int s = 0; s < 3; s++) begin
         pick();
         pll_enable = 1'b0;
         output_mux_select = 1'b1;
         // ratio kept in range, reference rate scaled to bench clocks
         div_q = (s == 0) ? ACG_Q_MIN : (s == 1) ? ACG_Q_MAX : 5'(rnd(2, 17));
         if (dac_rate_divider[0])
            div_q = div_q & 5'h1E;
         run_cfg(2'(s), 2'(rnd(0, 1)));
         mn = (1 << clkout_m_sel) * clkout_n;
         verify(cnt[s] * 2 / div_q, cnt[s] * 4 / mn);
      end
      // loop path from each source, the spare one with the codec down
      for (int l = 0; l < 3; l++) begin
         int d;
         pick();
         // vco-fed output divider stays below one tick per cycle
         clkout_m_sel = 2'(rnd(2, 3));
         pll_enable = 1'b1;
         codec_powered_down = (l == 2);
         // fractional multiplier keeps J small and R at one
         pll_j = 7'(rnd(4, 11));
         pll_d = 14'(rnd(0, 9999));
         pll_r = 5'h01;
         pll_p = 4'(rnd(4, 8));
         if (l == 2) begin
            // integer multiplier within its J range
            pll_j = 7'(rnd(4, 31));
            pll_d = 14'h0000;
            pll_r = 5'(rnd(1, 2));
            pll_p = ACG_P_MAX;
         end
         output_mux_select = (l == 2) ? 1'b0 : 1'(rnd(0, 1));
         d = rnd(0, 2);
         run_cfg(2'(d), 2'(l));
         kn = (pll_j * 10000 + pll_d) * pll_r;
         kd = pll_p * 10000;
         mn = (1 << clkout_m_sel) * clkout_n;
         verify((l == 2) ? 0 : cnt[l] * kn / (kd * 8),
                output_mux_select ? cnt[d] * 4 / mn : cnt[l] * kn * 4 / (kd * mn));
      end
      // a change under running consumers is held until they stop
      @(negedge sys_clk);
      div_q = div_q ^ 5'h01;
      repeat (2) @(negedge sys_clk);
      check8("cfg_pending", {7'h00, cfg_pending}, 8'h01);
      {dac_enable, adc_enable, clkout_enable} = 3'h0;
      repeat (4) @(negedge sys_clk);
      check8("cfg_pending", {7'h00, cfg_pending}, 8'h00);
      end_of_test();
   end

   // cut a hung run short
   initial begin
      #(40 * 90000);
      err_total++;
      end_of_test();
   end
endmodule // tb_top
